// [rtl/hcm_consts.vh]
`ifndef HCM_CONSTS_VH
`define HCM_CONSTS_VH

// ****************************************************************
// Special function register map
// ****************************************************************
`define HCM_SFR_CONFIG_READ_ADDRESS      8'h93
`define HCM_SFR_CONFIG_READ_DATA      8'h94

// ****************************************************************
// Configuration memory geometry and code-space window
// ****************************************************************
`define HCM_AW             7
`define HCM_DW             8
`define HCM_WORDS          128
`define HCM_CODE_PAGE      9'h100
`define HCM_IDX_BPC        7'h7E
`define HCM_IDX_SFC        7'h7F
`define HCM_USER_FIRST     7'h02
`define HCM_USER_LAST      7'h6F

// ****************************************************************
// Security and flash byte fields
// ****************************************************************
`define HCM_SFC_ACCESS     7
`define HCM_SFC_PLOCK      6
`define HCM_SFC_BLOCK      5
`define HCM_SFC_BROM       4
`define HCM_SFC_WDRST      3
`define HCM_SFC_DFS_HI     2
`define HCM_SFC_DFS_LO     0
`define HCM_SFC_DEFAULT    8'hBF

// ****************************************************************
// Brownout and port byte fields
// ****************************************************************
`define HCM_BPC_DBL_HI     7
`define HCM_BPC_DBL_LO     6
`define HCM_BPC_ABL_HI     5
`define HCM_BPC_ABL_LO     4
`define HCM_BPC_AOFF       3
`define HCM_BPC_DOFF       2
`define HCM_BPC_P0IO       1
`define HCM_BPC_P23IO      0
`define HCM_BPC_DEFAULT    8'hF3

// ****************************************************************
// Flash partition figures in kilobytes, and the none and reserved data flash size codes
// ****************************************************************
`define HCM_DFS_BASE_KB    8'h40
`define HCM_DFS_NONE       3'h7
`define HCM_DFS_RSVD       3'h0
`define HCM_BOOT_KB        8'h04
`define HCM_FLASH_KB       8'h20

`endif

// [rtl/hcm_cfg_mem.v]
`default_nettype none

// ****************************************************************
// Configuration byte store, one write port, two registered reads
// ****************************************************************
`include "hcm_consts.vh"

module hcm_cfg_mem (
  input  wire                     ref_clk_i,
  input  wire                     we_i,
  input  wire [`HCM_AW-1:0]       waddr_i,
  input  wire [`HCM_DW-1:0]       wdata_i,
  input  wire [`HCM_AW-1:0]       ra_addr_i,
  output reg  [`HCM_DW-1:0]       ra_data_o,
  input  wire [`HCM_AW-1:0]       rb_addr_i,
  output reg  [`HCM_DW-1:0]       rb_data_o
);

  // No reset: contents model nonvolatile cells
  reg [`HCM_DW-1:0] mem_ff [0:`HCM_WORDS-1];

  always @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    ra_data_o <= mem_ff[ra_addr_i];
    rb_data_o <= mem_ff[rb_addr_i];
  end

endmodule // hcm_cfg_mem

`default_nettype wire

// [rtl/hcm_cfg_decode.v]
`default_nettype none

// ****************************************************************
// Turns the two held configuration bytes into registered controls
// ****************************************************************
`include "hcm_consts.vh"

module hcm_cfg_decode #(
  parameter [7:0] FLASH_KB = `HCM_FLASH_KB
) (
  input  wire       ref_clk_i,
  input  wire       rst_i,
  input  wire [7:0] sfc_i,
  input  wire [7:0] bpc_i,
  output reg        program_access_allow_o,
  output reg        program_flash_write_lock_o,
  output reg        boot_sector_write_lock_o,
  output reg        boot_rom_on_o,
  output reg  [7:0] data_flash_kb_o,
  output reg  [7:0] program_flash_kb_o,
  output reg  [1:0] digital_brownout_level_o,
  output reg  [1:0] analog_brownout_level_o,
  output reg        digital_brownout_en_o,
  output reg        analog_brownout_en_o,
  output reg        port_zero_gpio_on_o,
  output reg        ports_two_three_gpio_on_o,
  output reg        ext_mem_strobes_o
);

  function [7:0] dfs_kb;
    input [2:0] code;
    begin
      if (code == `HCM_DFS_NONE || code == `HCM_DFS_RSVD) begin
        dfs_kb = 8'h00;
      end else begin
        dfs_kb = `HCM_DFS_BASE_KB >> code;
      end
    end
  endfunction

  wire [7:0] sel_kb  = dfs_kb(sfc_i[`HCM_SFC_DFS_HI:`HCM_SFC_DFS_LO]);
  wire [7:0] data_kb = (sel_kb > FLASH_KB) ? FLASH_KB : sel_kb;
  wire [7:0] prog_kb = FLASH_KB - data_kb;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      program_access_allow_o     <= 1'b1;
      program_flash_write_lock_o <= 1'b0;
      boot_sector_write_lock_o   <= 1'b1;
      boot_rom_on_o              <= 1'b1;
      data_flash_kb_o            <= 8'h00;
      program_flash_kb_o         <= FLASH_KB;
      digital_brownout_level_o   <= 2'h3;
      analog_brownout_level_o    <= 2'h3;
      digital_brownout_en_o      <= 1'b1;
      analog_brownout_en_o       <= 1'b1;
      port_zero_gpio_on_o        <= 1'b1;
      ports_two_three_gpio_on_o  <= 1'b1;
      ext_mem_strobes_o          <= 1'b0;
    end else begin
      program_access_allow_o     <= sfc_i[`HCM_SFC_ACCESS];
      // A 4k program area lies wholly in the boot sector
      program_flash_write_lock_o <= sfc_i[`HCM_SFC_PLOCK] |
                                    (sfc_i[`HCM_SFC_BLOCK] & (prog_kb == `HCM_BOOT_KB));
      boot_sector_write_lock_o   <= sfc_i[`HCM_SFC_BLOCK];
      boot_rom_on_o              <= sfc_i[`HCM_SFC_BROM];
      data_flash_kb_o            <= data_kb;
      program_flash_kb_o         <= prog_kb;
      digital_brownout_level_o   <= bpc_i[`HCM_BPC_DBL_HI:`HCM_BPC_DBL_LO];
      analog_brownout_level_o    <= bpc_i[`HCM_BPC_ABL_HI:`HCM_BPC_ABL_LO];
      digital_brownout_en_o      <= ~bpc_i[`HCM_BPC_DOFF];
      analog_brownout_en_o       <= ~bpc_i[`HCM_BPC_AOFF];
      port_zero_gpio_on_o        <= bpc_i[`HCM_BPC_P0IO];
      ports_two_three_gpio_on_o  <= bpc_i[`HCM_BPC_P23IO];
      ext_mem_strobes_o          <= ~bpc_i[`HCM_BPC_P0IO] | ~bpc_i[`HCM_BPC_P23IO];
    end
  end

endmodule // hcm_cfg_decode

`default_nettype wire

// [rtl/hcm_top.v]
// Overview of operation
// - Holds 128 configuration bytes: two hardware bytes plus user data area.
// - Only programming mode may write; running software cannot modify any byte.
// - Security bit 7 clear blocks flash reads and writes; set keeps access.
// - Program lock bit 6 set rejects software writes to program flash.
// - Boot sector lock bit 5 protects first 4k; 4k program area means full lock.
// - Watchdog bit 3 picks reset when set, auxiliary interrupt when clear.
// - Three-bit field sizes data flash 32k down to 1k, 111 none.
// - Data request larger than physical flash gives all flash to data.
// - Digital brownout level bits 7-6 pick 4.5, 4.2, 2.7 or 2.5 volts.
// - Analog brownout level bits 5-4 use the same encoding.
// - Analog brownout off bit set suppresses analog brownout detection.
// - Digital brownout off bit set suppresses digital brownout detection.
// - Port zero bit clear makes port 0 the external bus with strobes.
// - Ports two/three bit clear makes them external bus with strobes.
// - User data sits at code 8002 to 806F, readable, never software-writable.
// - In programming mode the hardware bytes appear at code 807E and 807F.
// - Normal code reads of those addresses never return configuration bytes.
// - Address register at 93 selects bytes 00 to 7F; software keeps range.
// - Reading data register at 94 returns the byte at the held address.
// - Watchdog bit only picks the action, never enables the watchdog.

`default_nettype none

`include "hcm_consts.vh"

module hcm_top #(
  parameter [7:0] FLASH_KB = `HCM_FLASH_KB
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  input  wire [7:0]  sfr_wdata_i,
  output wire [7:0]  sfr_rdata_o,
  output wire        sfr_ack_o,
  input  wire        prog_mode_i,
  input  wire        prog_we_i,
  input  wire        code_rd_i,
  input  wire [15:0] code_addr_i,
  input  wire [7:0]  prog_wdata_i,
  output wire [7:0]  code_rdata_o,
  output wire        code_valid_o,
  output wire        prog_mode_o,
  input  wire        wdt_expire_i,
  output wire        wdt_reset_req_o,
  output wire        watchdog_irq_flag_o,
  output wire        cfg_loaded_o,
  output wire        program_access_allow_o,
  output wire        program_flash_write_lock_o,
  output wire        boot_sector_write_lock_o,
  output wire        boot_rom_on_o,
  output wire [7:0]  data_flash_kb_o,
  output wire [7:0]  program_flash_kb_o,
  output wire [1:0]  digital_brownout_level_o,
  output wire [1:0]  analog_brownout_level_o,
  output wire        digital_brownout_en_o,
  output wire        analog_brownout_en_o,
  output wire        port_zero_gpio_on_o,
  output wire        ports_two_three_gpio_on_o,
  output wire        ext_mem_strobes_o
);

  // ****************************************************************
  // Loader states
  // ****************************************************************
  localparam [1:0] ST_RD_BPC = 2'b00;
  localparam [1:0] ST_RD_SFC = 2'b01;
  localparam [1:0] ST_LATCH  = 2'b10;
  localparam [1:0] ST_RUN    = 2'b11;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0]         state_ff;
  reg  [1:0]         nxt_state;
  reg  [7:0]         sfc_ff;
  reg  [7:0]         bpc_ff;
  reg                loaded_ff;
  reg  [7:0]         config_read_address_ff;
  reg  [7:0]         sfr_rdata_ff;
  reg                sfr_ack_ff;
  reg                mode_s1_ff;
  reg                mode_s2_ff;
  reg                mode_s3_ff;
  reg                mode_ff;
  reg                code_pend_ff;
  reg                code_hit_ff;
  reg  [7:0]         code_rdata_ff;
  reg                code_valid_ff;
  reg                wdt_reset_ff;
  reg                wdt_irq_ff;
  reg  [`HCM_AW-1:0] ra_addr;
  wire [`HCM_DW-1:0] ra_data;
  wire [`HCM_DW-1:0] rb_data;
  wire               sel_config_read_address;
  wire               sel_config_read_data;
  wire               config_read_address_wr;
  wire               in_window;
  wire [`HCM_AW-1:0] code_idx;
  wire               idx_writable;
  wire               mem_we;

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  function is_writable;
    input [`HCM_AW-1:0] idx;
    begin
      is_writable = ((idx >= `HCM_USER_FIRST) && (idx <= `HCM_USER_LAST)) ||
                    (idx == `HCM_IDX_BPC) || (idx == `HCM_IDX_SFC);
    end
  endfunction

  assign sel_config_read_address    = (sfr_addr_i == `HCM_SFR_CONFIG_READ_ADDRESS);
  assign sel_config_read_data    = (sfr_addr_i == `HCM_SFR_CONFIG_READ_DATA);
  assign config_read_address_wr     = sfr_wr_i & sel_config_read_address;
  assign in_window    = (code_addr_i[15:`HCM_AW] == `HCM_CODE_PAGE);
  assign code_idx     = code_addr_i[`HCM_AW-1:0];
  assign idx_writable = is_writable(code_idx);

  // ****************************************************************
  // Programming-mode strap, three-stage synchroniser
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_s1_ff <= 1'b0;
      mode_s2_ff <= 1'b0;
      mode_s3_ff <= 1'b0;
      mode_ff    <= 1'b0;
    end else begin
      mode_s1_ff <= prog_mode_i;
      mode_s2_ff <= mode_s1_ff;
      mode_s3_ff <= mode_s2_ff;
      if (mode_s2_ff == mode_s3_ff) begin
        mode_ff <= mode_s3_ff;
      end
    end
  end

  // Only the programmer path reaches the write port; the SFR side has none
  assign mem_we = mode_ff & prog_we_i & in_window & idx_writable;

  // ****************************************************************
  // Configuration store
  // ****************************************************************
  hcm_cfg_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .waddr_i   (code_idx),
    .wdata_i   (prog_wdata_i),
    .ra_addr_i (ra_addr),
    .ra_data_o (ra_data),
    .rb_addr_i (code_idx),
    .rb_data_o (rb_data)
  );

  // ****************************************************************
  // Reset-time loader of the two hardware bytes
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RD_BPC: nxt_state = ST_RD_SFC;
      ST_RD_SFC: nxt_state = ST_LATCH;
      ST_LATCH:  nxt_state = ST_RUN;
      ST_RUN:    nxt_state = ST_RUN;
      default:   nxt_state = ST_RUN;
    endcase
  end

  // Port A serves the loader first, then tracks the address register.
  // An address write steers the read at once so the data is fresh next cycle.
  always @* begin
    case (state_ff)
      ST_RD_BPC: ra_addr = `HCM_IDX_BPC;
      ST_RD_SFC: ra_addr = `HCM_IDX_SFC;
      default:   ra_addr = config_read_address_wr ? sfr_wdata_i[`HCM_AW-1:0] :
                                      config_read_address_ff[`HCM_AW-1:0];
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= ST_RD_BPC;
      bpc_ff    <= `HCM_BPC_DEFAULT;
      sfc_ff    <= `HCM_SFC_DEFAULT;
      loaded_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Holding bytes are taken once; later programming waits for a reset
      if (state_ff == ST_RD_SFC) begin
        bpc_ff <= ra_data;
      end
      if (state_ff == ST_LATCH) begin
        sfc_ff    <= ra_data;
        loaded_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // SFR slave: address register and read-only data register
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      config_read_address_ff     <= 8'h00;
      sfr_rdata_ff <= 8'h00;
      sfr_ack_ff   <= 1'b0;
    end else begin
      if (config_read_address_wr) begin
        config_read_address_ff <= sfr_wdata_i;
      end
      sfr_ack_ff <= (sfr_rd_i | sfr_wr_i) & (sel_config_read_address | sel_config_read_data);
      if (sfr_rd_i & sel_config_read_address) begin
        sfr_rdata_ff <= config_read_address_ff;
      end else if (sfr_rd_i & sel_config_read_data) begin
        sfr_rdata_ff <= ra_data;
      end else begin
        // Writes to the data register fall here and change nothing
        sfr_rdata_ff <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Code-space read path: bytes visible only while programming
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_pend_ff  <= 1'b0;
      code_hit_ff   <= 1'b0;
      code_rdata_ff <= 8'h00;
      code_valid_ff <= 1'b0;
    end else begin
      code_pend_ff  <= code_rd_i;
      code_hit_ff   <= code_rd_i & in_window & mode_ff;
      code_valid_ff <= code_pend_ff;
      // Normal fetches of the window see zero, never configuration data
      code_rdata_ff <= code_hit_ff ? rb_data : 8'h00;
    end
  end

  // ****************************************************************
  // Watchdog expiry routing
  // ****************************************************************
  // Expiry only arrives from an enabled watchdog; this bit never enables it
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_reset_ff <= 1'b0;
      wdt_irq_ff   <= 1'b0;
    end else begin
      wdt_reset_ff <= wdt_expire_i & sfc_ff[`HCM_SFC_WDRST];
      wdt_irq_ff   <= wdt_expire_i & ~sfc_ff[`HCM_SFC_WDRST];
    end
  end

  // ****************************************************************
  // Control decode
  // ****************************************************************
  hcm_cfg_decode #(
    .FLASH_KB (FLASH_KB)
  ) u_dec (
    .ref_clk_i                  (ref_clk_i),
    .rst_i                      (rst_i),
    .sfc_i                      (sfc_ff),
    .bpc_i                      (bpc_ff),
    .program_access_allow_o     (program_access_allow_o),
    .program_flash_write_lock_o (program_flash_write_lock_o),
    .boot_sector_write_lock_o   (boot_sector_write_lock_o),
    .boot_rom_on_o              (boot_rom_on_o),
    .data_flash_kb_o            (data_flash_kb_o),
    .program_flash_kb_o         (program_flash_kb_o),
    .digital_brownout_level_o   (digital_brownout_level_o),
    .analog_brownout_level_o    (analog_brownout_level_o),
    .digital_brownout_en_o      (digital_brownout_en_o),
    .analog_brownout_en_o       (analog_brownout_en_o),
    .port_zero_gpio_on_o        (port_zero_gpio_on_o),
    .ports_two_three_gpio_on_o  (ports_two_three_gpio_on_o),
    .ext_mem_strobes_o          (ext_mem_strobes_o)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sfr_rdata_o         = sfr_rdata_ff;
  assign sfr_ack_o           = sfr_ack_ff;
  assign code_rdata_o        = code_rdata_ff;
  assign code_valid_o        = code_valid_ff;
  assign prog_mode_o         = mode_ff;
  assign wdt_reset_req_o     = wdt_reset_ff;
  assign watchdog_irq_flag_o = wdt_irq_ff;
  assign cfg_loaded_o        = loaded_ff;

endmodule // hcm_top

`default_nettype wire

// [tb/hcm_top_chk.sv]
`default_nettype none
module hcm_top_chk #(
  parameter [7:0] FLASH_KB = 8'h20
) (
  input wire       ref_clk_i,
  input wire       rst_i,
  input wire [7:0] sfr_addr_i,
  input wire       sfr_wr_i,
  input wire       sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       sfr_ack_o,
  input wire       code_rd_i,
  input wire [7:0] code_rdata_o,
  input wire       code_valid_o,
  input wire       prog_mode_o,
  input wire       wdt_expire_i,
  input wire       wdt_reset_req_o,
  input wire       watchdog_irq_flag_o,
  input wire       cfg_loaded_o,
  input wire       program_flash_write_lock_o,
  input wire       boot_sector_write_lock_o,
  input wire [7:0] data_flash_kb_o,
  input wire [7:0] program_flash_kb_o,
  input wire       port_zero_gpio_on_o,
  input wire       ports_two_three_gpio_on_o,
  input wire       ext_mem_strobes_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  wire        mapped = (sfr_addr_i == 8'h93) || (sfr_addr_i == 8'h94);
  wire        req    = sfr_rd_i || sfr_wr_i;
  // Decoded controls lag the load by one edge, hence the two-cycle guard below
  wire [20:0] held   = {program_flash_write_lock_o, boot_sector_write_lock_o, data_flash_kb_o,
                        program_flash_kb_o, port_zero_gpio_on_o, ports_two_three_gpio_on_o,
                        ext_mem_strobes_o};

  a_ack_mapped: assert property (req && mapped |=> sfr_ack_o)
    else $error("mapped access not acknowledged");
  a_ack_unmapped: assert property (!(req && mapped) |=> !sfr_ack_o)
    else $error("acknowledge without mapped access");
  a_rdata_idle: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
    else $error("read data not cleared");
  a_addr_back: assert property (sfr_wr_i && sfr_addr_i == 8'h93 ##1 sfr_rd_i && !sfr_wr_i
    && sfr_addr_i == 8'h93 |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("address register read back wrong");
  a_code_hidden: assert property (code_rd_i && !prog_mode_o |-> ##2 code_valid_o
    && code_rdata_o == 8'h00)
    else $error("code read exposed configuration");
  a_wdt_one: assert property (wdt_expire_i |=> wdt_reset_req_o != watchdog_irq_flag_o)
    else $error("watchdog action not exactly one");
  a_wdt_quiet: assert property (!wdt_expire_i |=> !wdt_reset_req_o && !watchdog_irq_flag_o)
    else $error("watchdog action without expiry");
  a_cfg_hold: assert property (cfg_loaded_o && $past(cfg_loaded_o, 2) |-> $stable(held))
    else $error("decoded configuration changed");
  a_split_sum: assert property (data_flash_kb_o + program_flash_kb_o == FLASH_KB)
    else $error("flash split does not add up");
  a_small_lock: assert property (boot_sector_write_lock_o && program_flash_kb_o == 8'h04
    |-> program_flash_write_lock_o)
    else $error("boot lock on small program area not full lock");
  a_strobe_use: assert property (ext_mem_strobes_o ==
    (!port_zero_gpio_on_o || !ports_two_three_gpio_on_o))
    else $error("external strobe select wrong");
endmodule // hcm_top_chk

bind hcm_top hcm_top_chk #(.FLASH_KB(FLASH_KB)) i_hcm_top_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .sfr_ack_o(sfr_ack_o), .code_rd_i(code_rd_i), .code_rdata_o(code_rdata_o),
  .code_valid_o(code_valid_o), .prog_mode_o(prog_mode_o), .wdt_expire_i(wdt_expire_i),
  .wdt_reset_req_o(wdt_reset_req_o), .watchdog_irq_flag_o(watchdog_irq_flag_o),
  .cfg_loaded_o(cfg_loaded_o), .program_flash_write_lock_o(program_flash_write_lock_o),
  .boot_sector_write_lock_o(boot_sector_write_lock_o), .data_flash_kb_o(data_flash_kb_o),
  .program_flash_kb_o(program_flash_kb_o), .port_zero_gpio_on_o(port_zero_gpio_on_o),
  .ports_two_three_gpio_on_o(ports_two_three_gpio_on_o),
  .ext_mem_strobes_o(ext_mem_strobes_o));
`default_nettype wire

// [tb/hcm_core_model.sv]
`default_nettype none
module hcm_core_model (
  input  wire             ref_clk_i,
  input  wire       [7:0] rdata_i,
  input  wire             ack_i,
  output var  logic [7:0] addr_o,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Entered just after an edge; strobes stay up so calls may run back to back
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic ack, output logic [7:0] rd);
    addr_o = a;
    wdata_o = d;
    wr_o = wr;
    rd_o = ~wr;
    @(posedge ref_clk_i);
    #1;
    ack = ack_i;
    rd = rdata_i;
  endtask

  // Released lines show the inverse so a stale value never passes as valid
  task automatic idle;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
endmodule // hcm_core_model
`default_nettype wire

// [tb/hcm_top_tb.sv]
`default_nettype none
module hcm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Small flash so that large data selections overflow the part
  localparam logic [7:0] FKB = 8'h08;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pm = 1'b0;
  logic        pwe = 1'b0;
  logic        crd = 1'b0;
  logic [15:0] ca = 16'h0000;
  logic [7:0]  pwd = 8'h00;
  logic        wx = 1'b0;
  wire  [7:0]  sa, swd, srd, crdat, dkb, pkb;
  wire  [1:0]  dl, al;
  wire         swr, srq, sak, cv, pmo, wrst, wirq, ld;
  wire         acc, plk, bsl, brm, den, aen, p0, p23, stb;
  wire  [8:0]  bs = {dl, al, den, aen, p0, p23, stb};
  wire  [3:0]  ss = {acc, plk, bsl, brm};
  int          num_errors = 0;
  int          comparisons = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  hcm_top #(.FLASH_KB(FKB)) i_hcm_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sa), .sfr_wr_i(swr),
    .sfr_rd_i(srq), .sfr_wdata_i(swd), .sfr_rdata_o(srd), .sfr_ack_o(sak),
    .prog_mode_i(pm), .prog_we_i(pwe), .code_rd_i(crd), .code_addr_i(ca),
    .prog_wdata_i(pwd), .code_rdata_o(crdat), .code_valid_o(cv), .prog_mode_o(pmo),
    .wdt_expire_i(wx), .wdt_reset_req_o(wrst), .watchdog_irq_flag_o(wirq),
    .cfg_loaded_o(ld), .program_access_allow_o(acc), .program_flash_write_lock_o(plk),
    .boot_sector_write_lock_o(bsl), .boot_rom_on_o(brm), .data_flash_kb_o(dkb),
    .program_flash_kb_o(pkb), .digital_brownout_level_o(dl), .analog_brownout_level_o(al),
    .digital_brownout_en_o(den), .analog_brownout_en_o(aen), .port_zero_gpio_on_o(p0),
    .ports_two_three_gpio_on_o(p23), .ext_mem_strobes_o(stb));

  hcm_core_model i_hcm_core_model (
    .ref_clk_i(ref_clk_i), .rdata_i(srd), .ack_i(sak), .addr_o(sa), .wr_o(swr),
    .rd_o(srq), .wdata_o(swd));

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic mode(input logic on);
    pwe = 1'b0;
    pm = on;
    step(6);
    chk("prog_mode", {15'h0000, on}, {15'h0000, pmo});
  endtask

  task automatic prog(input logic [6:0] idx, input logic [7:0] d);
    pwe = 1'b1;
    ca = {9'h100, idx};
    pwd = d;
    step(1);
  endtask

  // Programs both hardware bytes and the first and last user bytes, then reloads through reset
  task automatic load(input logic [7:0] sfc, input logic [7:0] bpc);
    mode(1'b1);
    prog(7'h7F, sfc);
    prog(7'h7E, bpc);
    prog(7'h02, 8'h5A);
    prog(7'h6F, 8'hA5);
    mode(1'b0);
    prog(7'h02, 8'hFF);
    pwe = 1'b0;
    rst_i = 1'b1;
    step(2);
    rst_i = 1'b0;
    step(3);
    chk("cfg_loaded", 16'h0001, {15'h0000, ld});
    step(1);
  endtask

  task automatic t_decode;
    logic [2:0]  c;
    logic [7:0]  sfc, bpc, d;
    logic [8:0]  eb;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      // Program lock, boot lock and boot ROM bits each take both values over the loop
      sfc = {c[1], c == 3'h6, c != 3'h0, c[0] | ~c[1], c[0], c};
      bpc = {c[1:0], ~c[1:0], c[2], ~c[2], c[0], c[1]};
      d = (c == 3'h0 || c == 3'h7) ? 8'h00 : 8'h40 >> c;
      if (d > FKB) d = FKB;
      eb = {bpc[7:4], ~bpc[2], ~bpc[3], bpc[1:0], ~(bpc[1] & bpc[0])};
      load(sfc, bpc);
      chk("data_kb", {8'h00, d}, {8'h00, dkb});
      chk("prog_kb", {8'h00, FKB - d}, {8'h00, pkb});
      chk("sec", {12'h000, sfc[7], sfc[6] | (sfc[5] & (FKB - d == 8'h04)), sfc[5:4]},
          {12'h000, ss});
      chk("bpc", {7'h00, eb}, {7'h00, bs});
      wx = 1'b1;
      step(1);
      wx = 1'b0;
      chk("wdt", {14'h0000, c[0], ~c[0]}, {14'h0000, wrst, wirq});
      step(1);
      chk("wdt_idle", 16'h0000, {14'h0000, wrst, wirq});
    end
  endtask

  task automatic sq(input logic wr, input logic [7:0] a, input logic [7:0] dat,
                    input logic ek, input logic [7:0] er);
    logic       k;
    logic [7:0] r;
    i_hcm_core_model.access(wr, a, dat, k, r);
    chk("sfr_ack", {15'h0000, ek}, {15'h0000, k});
    chk("sfr_rdata", {8'h00, er}, {8'h00, r});
  endtask

  task automatic t_sfr;
    sq(1'b1, 8'h93, 8'h02, 1'b1, 8'h00);
    sq(1'b0, 8'h94, 8'h00, 1'b1, 8'h5A);
    sq(1'b1, 8'h94, 8'hFF, 1'b1, 8'h00);
    sq(1'b0, 8'h94, 8'h00, 1'b1, 8'h5A);
    sq(1'b1, 8'h93, 8'h6F, 1'b1, 8'h00);
    sq(1'b0, 8'h93, 8'h00, 1'b1, 8'h6F);
    sq(1'b0, 8'h94, 8'h00, 1'b1, 8'hA5);
    sq(1'b1, 8'h93, 8'h7F, 1'b1, 8'h00);
    sq(1'b0, 8'h94, 8'h00, 1'b1, 8'hBF);
    sq(1'b1, 8'h93, 8'h7E, 1'b1, 8'h00);
    sq(1'b0, 8'h94, 8'h00, 1'b1, 8'hCB);
    sq(1'b0, 8'h95, 8'h00, 1'b0, 8'h00);
    i_hcm_core_model.idle();
    step(1);
  endtask

  task automatic cr(input logic [15:0] a, input logic [7:0] er);
    crd = 1'b1;
    ca = a;
    step(1);
    crd = 1'b0;
    step(1);
    chk("code_valid", 16'h0001, {15'h0000, cv});
    chk("code_rdata", {8'h00, er}, {8'h00, crdat});
  endtask

  task automatic t_code;
    mode(1'b1);
    cr(16'h807F, 8'hBF);
    cr(16'h807E, 8'hCB);
    cr(16'h8002, 8'h5A);
    mode(1'b0);
    cr(16'h807F, 8'h00);
    cr(16'h8002, 8'h00);
  endtask

  initial begin
    // Cells start erased so the load after the first reset sees defined bytes
    for (int i = 0; i < 128; i++) begin
      i_hcm_top.u_mem.mem_ff[i] = 8'hFF;
    end
    step(8);
    rst_i = 1'b0;
    t_decode;
    t_sfr;
    t_code;
    test_done;
  end

  initial begin
    #(50 * 3000);
    num_errors++;
    test_done;
  end
endmodule // hcm_top_tb
`default_nettype wire
